// ---- core/cdpx_cfg.svh ----
// Purpose: Offsets, field positions, reset values and counts for the waveform extension.
// Assumes: Included by its bare name from the package users.
// Notes: Definitions only.
`ifndef CDPX_CFG_SVH
`define CDPX_CFG_SVH
`define CDPX_OFF_CTRL 8'h00
`define CDPX_OFF_FAULT 8'h04
`define CDPX_OFF_STATUS 8'h08
`define CDPX_OFF_MASK 8'h0c
`define CDPX_OFF_DT_LS_BUF 8'h10
`define CDPX_OFF_DT_HS_BUF 8'h14
`define CDPX_OFF_OVR 8'h18
`define CDPX_OFF_PAT_BUF 8'h1c
`define CDPX_OFF_DT_ACT 8'h20
`define CDPX_OFF_FLT_SEL 8'h24
`define CDPX_CTRL_DTI_EN 0
`define CDPX_CTRL_PGM_EN 1
`define CDPX_CTRL_CWCM 2
`define CDPX_CTRL_DTHALT 3
`define CDPX_ST_FAULT 0
`define CDPX_ST_UPDATE 1
`define CDPX_ST_DTSTALL 2
`define CDPX_FLT_LATCHED 0
`define CDPX_RST_CTRL 4'h0
`define CDPX_RST_DT 8'h00
`define CDPX_RST_OVR 8'h00
`define CDPX_RST_PAT 8'h00
`define CDPX_RST_MASK 3'h0
`define CDPX_RST_FLT_SEL 8'h00
`define CDPX_NUM_CH 4
`define CDPX_NUM_PINS 8
`define CDPX_NUM_EVT 8
`endif

// ---- core/cdpx_pkg.sv ----
// Purpose: Types shared by the waveform extension files.
// Assumes: 32-bit data on the register bus.
// Notes: Numbers live in the cfg header.
package cdpx_pkg;
    typedef struct packed {
        logic [7:0] pin_val;
        logic [7:0] pin_ovr;
    } cdpx_port_t;
    typedef enum logic [1:0] {
        CDPX_DT_IDLE = 2'b00,
        CDPX_DT_WAIT = 2'b01,
        CDPX_DT_DRIVE = 2'b11
    } cdpx_dt_state_t;
    typedef enum logic [1:0] {
        CDPX_RESP_OKAY = 2'b00,
        CDPX_RESP_SLVERR = 2'b10
    } cdpx_resp_t;
endpackage

// ---- core/cdpx_dead_time_inserter.sv ----
// Purpose: One dead-time unit: splits a waveform into low-side and high-side outputs.
// Assumes: Dead times counted in clock cycles; zero gives no gap.
// Notes: Neither output is active while the gap runs.
`timescale 1ns/10ps
`include "cdpx_cfg.svh"
module cdpx_dead_time_inserter (
    input wire logic mclk,
    input wire logic reset_n,
    input wire logic waveform_output,
    input wire logic [7:0] dt_ls,
    input wire logic [7:0] dt_hs,
    output logic low_side_output,
    output logic high_side_output,
    output logic in_dead_time
);
    import cdpx_pkg::*;
    cdpx_dt_state_t state_ff;
    cdpx_dt_state_t nxt_state;
    logic [7:0] cnt_ff;
    logic [7:0] nxt_cnt;
    logic level_ff;
    logic nxt_level;
    logic edge_seen;
    logic [7:0] gap;

    // A change of the waveform starts a gap sized for the side about to turn on.
    assign edge_seen = waveform_output != level_ff;
    assign gap = waveform_output ? dt_ls : dt_hs;

    // Gap sequencing.
    always_comb begin
        nxt_state = state_ff;
        nxt_cnt = cnt_ff;
        nxt_level = level_ff;
        if (edge_seen) begin
            nxt_level = waveform_output;
            nxt_cnt = gap;
            nxt_state = (gap == 8'h00) ? CDPX_DT_DRIVE : CDPX_DT_WAIT;
        end else begin
            case (state_ff)
                CDPX_DT_WAIT: begin
                    nxt_cnt = cnt_ff - 8'h01;
                    if (cnt_ff == 8'h01) begin
                        nxt_state = CDPX_DT_DRIVE;
                    end
                end
                default: begin
                    nxt_state = CDPX_DT_DRIVE;
                end
            endcase
        end
    end

    // State registers.
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            state_ff <= CDPX_DT_IDLE;
            cnt_ff <= `CDPX_RST_DT;
            level_ff <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            cnt_ff <= nxt_cnt;
            level_ff <= nxt_level;
        end
    end

    // Low side follows the waveform, high side its inverse, both off in the gap.
    assign low_side_output = (state_ff == CDPX_DT_DRIVE) & level_ff; // RULE4 RULE14
    assign high_side_output = (state_ff == CDPX_DT_DRIVE) & ~level_ff; // RULE4 RULE14
    assign in_dead_time = (state_ff == CDPX_DT_WAIT);

    // A waveform change with a nonzero dead time starts the gap.
    sequence s_gap_start;
        edge_seen && gap != 8'h00;
    endsequence

    // The last counted gap cycle with no new change.
    sequence s_gap_last;
        state_ff == CDPX_DT_WAIT && cnt_ff == 8'h01 && !edge_seen;
    endsequence

    property p_gap_blocks;
        @(posedge mclk) disable iff (!reset_n)
        s_gap_start |=> !(low_side_output || high_side_output) && (cnt_ff == $past(gap));
    endproperty
    a_gap_blocks: assert property (p_gap_blocks) else $error("Output active during dead time."); // RULE14

    property p_gap_len;
        @(posedge mclk) disable iff (!reset_n)
        s_gap_last |=> (state_ff == CDPX_DT_DRIVE);
    endproperty
    a_gap_len: assert property (p_gap_len) else $error("Dead time length wrong."); // RULE14
endmodule

// ---- core/cdpx_top.sv ----
// Purpose: Complementary dead-time, pattern and fault extension of a 16-bit timer.
// Assumes: AXI4-Lite slave with one write and one read at a time; timer inputs synchronous.
// Notes: Port outputs replace pins where pin_ovr is high.
// What this block does
// RULE1: Extension acts only in waveform generation mode.
// RULE2: Any feature on splits outputs into pairs.
// RULE3: Four dead-time units, one per channel.
// RULE4: Low side follows waveform, high side inverts.
// RULE5: Separate 8-bit low and high dead times.
// RULE6: Dead times double buffered before use.
// RULE7: Optionally halt timer during dead time.
// RULE8: Unit outputs replace selected port pins.
// RULE9: Pattern unit drives synchronized port pattern.
// RULE10: Pattern double buffered until transfer.
// RULE11: Optionally spread channel A over pins.
// RULE12: Pattern mode bypasses dead-time units.
// RULE13: Selected event fault disables outputs immediately; here the registered pin values clear one clock after the event.
// RULE14: Dead time counts clocks, both sides off.
// RULE15: Buffers transfer at the timer update.
// RULE16: Fault stays latched until written clear.
//
// Added by the designer: the register addresses and the AXI4-Lite slave port.
`timescale 1ns/10ps
`include "cdpx_cfg.svh"
module cdpx_top (
    input wire logic mclk,
    input wire logic reset_n,
    input wire logic [31:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [31:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [3:0] waveform_output,
    input wire logic wg_mode,
    input wire logic timer_update,
    input wire logic [7:0] event_in,
    output logic timer_halt,
    output cdpx_pkg::cdpx_port_t port_c_waveform_extension,
    output logic irq
);
    import cdpx_pkg::*;

    logic [3:0] ctrl_ff;
    logic [7:0] dt_ls_buf_ff;
    logic [7:0] dt_hs_buf_ff;
    logic [7:0] dt_ls_ff;
    logic [7:0] dt_hs_ff;
    logic dt_pend_ff;
    logic [7:0] ovr_ff;
    logic [7:0] pat_buf_ff;
    logic [7:0] pat_ff;
    logic pat_pend_ff;
    logic [7:0] flt_sel_ff;
    logic fault_ff;
    logic [2:0] status_ff;
    logic [2:0] mask_ff;
    logic irq_ff;
    logic timer_halt_ff;
    cdpx_port_t port_ff;
    logic aw_ff;
    logic w_ff;
    logic [7:0] awaddr_ff;
    logic [31:0] wdata_ff;
    logic [3:0] wstrb_ff;
    logic bvalid_ff;
    logic [1:0] bresp_ff;
    logic rvalid_ff;
    logic [31:0] rdata_ff;
    logic [1:0] rresp_ff;

    // Byte-lane write merge for the low byte of a register.
    function automatic logic [7:0] lane0(input logic [7:0] old, input logic [31:0] d, input logic [3:0] s);
        lane0 = s[0] ? d[7:0] : old;
    endfunction

    // Write channel capture, in either order.
    wire wr_go = aw_ff & w_ff & ~bvalid_ff;
    wire aw_take = s_axi_awvalid & ~aw_ff & ~bvalid_ff;
    wire w_take = s_axi_wvalid & ~w_ff & ~bvalid_ff;
    wire ar_take = s_axi_arvalid & ~rvalid_ff;
    wire wr_ctrl = wr_go && awaddr_ff == `CDPX_OFF_CTRL;
    wire wr_fault = wr_go && awaddr_ff == `CDPX_OFF_FAULT;
    wire wr_status = wr_go && awaddr_ff == `CDPX_OFF_STATUS;
    wire wr_mask = wr_go && awaddr_ff == `CDPX_OFF_MASK;
    wire wr_dtls = wr_go && awaddr_ff == `CDPX_OFF_DT_LS_BUF;
    wire wr_dths = wr_go && awaddr_ff == `CDPX_OFF_DT_HS_BUF;
    wire wr_ovr = wr_go && awaddr_ff == `CDPX_OFF_OVR;
    wire wr_pat = wr_go && awaddr_ff == `CDPX_OFF_PAT_BUF;
    wire wr_fsel = wr_go && awaddr_ff == `CDPX_OFF_FLT_SEL;
    wire wr_hit = wr_ctrl | wr_fault | wr_status | wr_mask | wr_dtls | wr_dths | wr_ovr | wr_pat | wr_fsel;

    // Mode decode.
    wire dti_en = ctrl_ff[`CDPX_CTRL_DTI_EN];
    wire pgm_en = ctrl_ff[`CDPX_CTRL_PGM_EN];
    wire cwcm = ctrl_ff[`CDPX_CTRL_CWCM];
    wire ext_on = wg_mode & (dti_en | pgm_en | cwcm); // RULE1 RULE2
    wire fault_evt = |(event_in & flt_sel_ff); // RULE13
    wire fault_now = fault_ff | fault_evt; // RULE13

    // Dead-time units, one per compare channel.
    logic [3:0] ls_w;
    logic [3:0] hs_w;
    logic [3:0] dt_busy;
    genvar gi;
    generate
        for (gi = 0; gi < `CDPX_NUM_CH; gi++) begin : g_dti
            cdpx_dead_time_inserter u_dti ( // RULE3
                .mclk(mclk),
                .reset_n(reset_n),
                .waveform_output(waveform_output[gi]),
                .dt_ls(dt_ls_ff),
                .dt_hs(dt_hs_ff),
                .low_side_output(ls_w[gi]),
                .high_side_output(hs_w[gi]),
                .in_dead_time(dt_busy[gi])
            );
        end
    endgenerate

    // Pin values: pattern mode bypasses the pairs, channel A spread optional.
    logic [7:0] pair_pins;
    generate
        for (gi = 0; gi < `CDPX_NUM_CH; gi++) begin : g_pair
            assign pair_pins[2*gi] = ls_w[gi]; // RULE4
            assign pair_pins[2*gi+1] = hs_w[gi]; // RULE4
        end
    endgenerate
    wire [7:0] src_pins = cwcm ? {8{pair_pins[0]}} : pair_pins; // RULE11
    wire [7:0] sel_val = pgm_en ? pat_ff : src_pins; // RULE9 RULE12
    wire [7:0] nxt_val = fault_now ? 8'h00 : sel_val; // RULE13
    wire [7:0] nxt_ovr = ext_on ? (cwcm ? 8'hff : ovr_ff) : 8'h00; // RULE8 RULE11 RULE1
    wire nxt_halt = ext_on & ctrl_ff[`CDPX_CTRL_DTHALT] & dti_en & ~pgm_en & (|dt_busy); // RULE7

    // Status events.
    wire [2:0] evt = {nxt_halt, timer_update, fault_evt};
    wire [2:0] nxt_status = (status_ff & ~(wr_status && wstrb_ff[0] ? wdata_ff[2:0] : 3'h0)) | evt;

    // Register read decode.
    wire [7:0] ra = s_axi_araddr[7:0];
    logic [31:0] rd_val;
    logic rd_ok;
    always_comb begin
        rd_ok = 1'b1;
        rd_val = 32'h0;
        if (ra == `CDPX_OFF_CTRL) begin
            rd_val = {28'h0, ctrl_ff};
        end else if (ra == `CDPX_OFF_FAULT) begin
            rd_val = {31'h0, fault_ff};
        end else if (ra == `CDPX_OFF_STATUS) begin
            rd_val = {29'h0, status_ff};
        end else if (ra == `CDPX_OFF_MASK) begin
            rd_val = {29'h0, mask_ff};
        end else if (ra == `CDPX_OFF_DT_LS_BUF) begin
            rd_val = {24'h0, dt_ls_buf_ff};
        end else if (ra == `CDPX_OFF_DT_HS_BUF) begin
            rd_val = {24'h0, dt_hs_buf_ff};
        end else if (ra == `CDPX_OFF_OVR) begin
            rd_val = {24'h0, ovr_ff};
        end else if (ra == `CDPX_OFF_PAT_BUF) begin
            rd_val = {24'h0, pat_buf_ff};
        end else if (ra == `CDPX_OFF_DT_ACT) begin
            rd_val = {16'h0, dt_hs_ff, dt_ls_ff};
        end else if (ra == `CDPX_OFF_FLT_SEL) begin
            rd_val = {24'h0, flt_sel_ff};
        end else begin
            rd_ok = 1'b0;
        end
    end

    // Bus handshake registers.
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            aw_ff <= 1'b0;
            w_ff <= 1'b0;
            awaddr_ff <= 8'h00;
            wdata_ff <= 32'h0;
            wstrb_ff <= 4'h0;
            bvalid_ff <= 1'b0;
            bresp_ff <= 2'b00;
        end else begin
            if (aw_take) begin
                aw_ff <= 1'b1;
                awaddr_ff <= s_axi_awaddr[7:0];
            end
            if (w_take) begin
                w_ff <= 1'b1;
                wdata_ff <= s_axi_wdata;
                wstrb_ff <= s_axi_wstrb;
            end
            if (wr_go) begin
                aw_ff <= 1'b0;
                w_ff <= 1'b0;
                bvalid_ff <= 1'b1;
                bresp_ff <= wr_hit ? CDPX_RESP_OKAY : CDPX_RESP_SLVERR;
            end else if (s_axi_bready) begin
                bvalid_ff <= 1'b0;
            end
        end
    end

    // Read channel.
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            rvalid_ff <= 1'b0;
            rdata_ff <= 32'h0;
            rresp_ff <= 2'b00;
        end else if (ar_take) begin
            rvalid_ff <= 1'b1;
            rdata_ff <= rd_val;
            rresp_ff <= rd_ok ? CDPX_RESP_OKAY : CDPX_RESP_SLVERR;
        end else if (s_axi_rready) begin
            rvalid_ff <= 1'b0;
        end
    end

    // Software-written configuration.
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            ctrl_ff <= `CDPX_RST_CTRL;
            mask_ff <= `CDPX_RST_MASK;
            ovr_ff <= `CDPX_RST_OVR;
            flt_sel_ff <= `CDPX_RST_FLT_SEL;
        end else begin
            if (wr_ctrl) ctrl_ff <= 4'(lane0({4'h0, ctrl_ff}, wdata_ff, wstrb_ff));
            if (wr_mask) mask_ff <= 3'(lane0({5'h0, mask_ff}, wdata_ff, wstrb_ff));
            if (wr_ovr) ovr_ff <= lane0(ovr_ff, wdata_ff, wstrb_ff);
            if (wr_fsel) flt_sel_ff <= lane0(flt_sel_ff, wdata_ff, wstrb_ff);
        end
    end

    // Double buffers move to active at the timer update.
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            dt_ls_buf_ff <= `CDPX_RST_DT;
            dt_hs_buf_ff <= `CDPX_RST_DT;
            dt_ls_ff <= `CDPX_RST_DT;
            dt_hs_ff <= `CDPX_RST_DT;
            dt_pend_ff <= 1'b0;
            pat_buf_ff <= `CDPX_RST_PAT;
            pat_ff <= `CDPX_RST_PAT;
            pat_pend_ff <= 1'b0;
        end else begin
            if (wr_dtls) dt_ls_buf_ff <= lane0(dt_ls_buf_ff, wdata_ff, wstrb_ff); // RULE5
            if (wr_dths) dt_hs_buf_ff <= lane0(dt_hs_buf_ff, wdata_ff, wstrb_ff); // RULE5
            if (wr_pat) pat_buf_ff <= lane0(pat_buf_ff, wdata_ff, wstrb_ff);
            if (timer_update && dt_pend_ff) begin
                dt_ls_ff <= dt_ls_buf_ff; // RULE6 RULE15
                dt_hs_ff <= dt_hs_buf_ff; // RULE6 RULE15
            end
            if (timer_update && pat_pend_ff) pat_ff <= pat_buf_ff; // RULE10 RULE15
            dt_pend_ff <= (wr_dtls | wr_dths) | (dt_pend_ff & ~timer_update);
            pat_pend_ff <= wr_pat | (pat_pend_ff & ~timer_update);
        end
    end

    // Fault latch, set wins over a clear write.
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            fault_ff <= 1'b0;
        end else begin
            fault_ff <= fault_evt | (fault_ff & ~(wr_fault && wstrb_ff[0] && wdata_ff[`CDPX_FLT_LATCHED])); // RULE16
        end
    end

    // Outputs, status and interrupt.
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            status_ff <= 3'h0;
            irq_ff <= 1'b0;
            timer_halt_ff <= 1'b0;
            port_ff <= '0;
        end else begin
            status_ff <= nxt_status;
            irq_ff <= |(nxt_status & mask_ff);
            timer_halt_ff <= nxt_halt;
            port_ff.pin_val <= nxt_val;
            port_ff.pin_ovr <= nxt_ovr;
        end
    end

    assign s_axi_awready = aw_take;
    assign s_axi_wready = w_take;
    assign s_axi_bvalid = bvalid_ff;
    assign s_axi_bresp = bresp_ff;
    assign s_axi_arready = ar_take;
    assign s_axi_rvalid = rvalid_ff;
    assign s_axi_rdata = rdata_ff;
    assign s_axi_rresp = rresp_ff;
    assign port_c_waveform_extension = port_ff;
    assign timer_halt = timer_halt_ff;
    assign irq = irq_ff;

    property p_fault_kills;
        @(posedge mclk) disable iff (!reset_n)
        fault_evt |=> (port_c_waveform_extension.pin_val == 8'h00);
    endproperty
    a_fault_kills: assert property (p_fault_kills) else $error("Fault did not clear outputs."); // RULE13

    property p_fault_holds;
        @(posedge mclk) disable iff (!reset_n)
        (fault_ff && !wr_fault) |=> fault_ff;
    endproperty
    a_fault_holds: assert property (p_fault_holds) else $error("Fault latch dropped."); // RULE16

    property p_no_wg;
        @(posedge mclk) disable iff (!reset_n)
        !wg_mode |=> (port_c_waveform_extension.pin_ovr == 8'h00);
    endproperty
    a_no_wg: assert property (p_no_wg) else $error("Override outside waveform mode."); // RULE1

    property p_dt_hold;
        @(posedge mclk) disable iff (!reset_n)
        !timer_update |=> $stable(dt_ls_ff) && $stable(dt_hs_ff);
    endproperty
    a_dt_hold: assert property (p_dt_hold) else $error("Dead time changed without update."); // RULE6

    property p_pat_hold;
        @(posedge mclk) disable iff (!reset_n)
        !timer_update |=> $stable(pat_ff);
    endproperty
    a_pat_hold: assert property (p_pat_hold) else $error("Pattern changed without update."); // RULE10

    property p_pat_out;
        @(posedge mclk) disable iff (!reset_n)
        (pgm_en && !fault_now) |=> (port_c_waveform_extension.pin_val == $past(pat_ff));
    endproperty
    a_pat_out: assert property (p_pat_out) else $error("Pattern not on pins."); // RULE12

    property p_spread;
        @(posedge mclk) disable iff (!reset_n)
        (ext_on && cwcm) |=> (port_c_waveform_extension.pin_ovr == 8'hff);
    endproperty
    a_spread: assert property (p_spread) else $error("Channel A not spread."); // RULE11

    property p_halt;
        @(posedge mclk) disable iff (!reset_n)
        timer_halt |-> ($past(dt_busy) != 4'h0);
    endproperty
    a_halt: assert property (p_halt) else $error("Halt without dead time."); // RULE7
endmodule

// ---- test/cdpx_power_stage.sv ----
// Purpose: Behavioural model of the external half-bridge gate drivers on the extension pins.
// Assumes: Pin 2k drives the low switch of leg k and pin 2k+1 the high switch.
// Notes: A leg with both switches on is latched as shoot-through.
`timescale 1ns/10ps
module cdpx_power_stage (
    input wire logic mclk,
    input wire logic reset_n,
    input wire cdpx_pkg::cdpx_port_t gate_in,
    output logic shoot_through
);
    import cdpx_pkg::*;
    logic [7:0] drive;
    logic [3:0] leg_short;
    // A pin reaches its gate only where overridden; the plain port level stays low.
    assign drive = gate_in.pin_val & gate_in.pin_ovr;
    assign leg_short = {drive[7] & drive[6], drive[5] & drive[4], drive[3] & drive[2], drive[1] & drive[0]};
    // Keeps any short once seen, as a blown bridge would.
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            shoot_through <= 1'b0;
        end else if (|leg_short) begin
            shoot_through <= 1'b1;
        end
    end
endmodule

// ---- test/cdpx_top_tb.sv ----
// Purpose: Self-checking bench for the waveform extension top.
// Assumes: One AXI4-Lite master; waits on handshakes, not on fixed latencies.
// Notes: Expected pin patterns follow the pair layout, pin 2k low side of channel k.
`timescale 1ns/10ps
`include "cdpx_cfg.svh"
module cdpx_top_tb;
    import cdpx_pkg::*;
    logic mclk, reset_n, awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
    logic [31:0] awaddr, wdata, araddr, rdata, rd_v;
    logic [1:0] bresp, rresp, resp_q;
    logic [3:0] wstrb, wave;
    logic wg_mode, timer_update, timer_halt, irq, shoot, halt_seen;
    logic [7:0] event_in;
    cdpx_port_t port_q;
    int failures, n_compared, n_gap;
    cdpx_top DUT (.mclk(mclk), .reset_n(reset_n), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .waveform_output(wave),
        .wg_mode(wg_mode), .timer_update(timer_update), .event_in(event_in), .timer_halt(timer_halt),
        .port_c_waveform_extension(port_q), .irq(irq));
    cdpx_power_stage stage (.mclk(mclk), .reset_n(reset_n), .gate_in(port_q), .shoot_through(shoot));
    // Free-running 100 MHz clock.
    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end
    // Counts a comparison and reports a mismatch at once.
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            failures++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    // Prints the verdict and ends the run.
    task automatic finish_test;
        if (failures == 0 && n_compared > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    // Register write; handshakes are judged at the negedge before the edge that takes them.
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic ah, wh, bh;
        @(posedge mclk);
        awaddr <= {24'h0, a};
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(negedge mclk);
            ah = awvalid & awready;
            wh = wvalid & wready;
            bh = bvalid;
            resp_q = bresp;
            @(posedge mclk);
            if (ah) awvalid <= 1'b0;
            if (wh) wvalid <= 1'b0;
        end while (bh !== 1'b1);
        bready <= 1'b0;
    endtask
    // Register read; data and response are taken at the edge where rvalid is high.
    task automatic rd(input logic [7:0] a);
        logic ah, rh;
        @(posedge mclk);
        araddr <= {24'h0, a};
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(negedge mclk);
            ah = arvalid & arready;
            rh = rvalid;
            rd_v = rdata;
            resp_q = rresp;
            @(posedge mclk);
            if (ah) arvalid <= 1'b0;
        end while (rh !== 1'b1);
        rready <= 1'b0;
    endtask
    // One-cycle pulses on the timer update and event inputs.
    task automatic pulse(input logic upd, input logic [7:0] ev);
        @(posedge mclk);
        timer_update <= upd;
        event_in <= ev;
        @(posedge mclk);
        timer_update <= 1'b0;
        event_in <= 8'h00;
    endtask
    // Sets the timer waveforms, lets them settle and stops at a falling edge.
    task automatic drive_wave(input logic [3:0] w, input int settle);
        @(posedge mclk);
        wave <= w;
        repeat (settle) @(posedge mclk);
        @(negedge mclk);
    endtask
    // Moves channel A and counts cycles with both pins of pair 0 off until on_bit rises.
    task automatic step_gap(input logic [3:0] w, input int on_bit);
        int t;
        @(posedge mclk);
        wave <= w;
        n_gap = 0;
        halt_seen = 1'b0;
        t = 0;
        do begin
            @(negedge mclk);
            if (port_q.pin_val[1:0] === 2'b00) n_gap++;
            if (timer_halt === 1'b1) halt_seen = 1'b1;
            t++;
        end while (port_q.pin_val[on_bit] !== 1'b1 && t < 60);
    endtask
    // Main sequence.
    initial begin
        reset_n = 1'b0;
        {awvalid, wvalid, bready, arvalid, rready, timer_update} = '0;
        {awaddr, wdata, araddr} = '0;
        wstrb = 4'h1;
        wave = 4'h0;
        wg_mode = 1'b1;
        event_in = 8'h00;
        failures = 0;
        n_compared = 0;
        repeat (4) @(posedge mclk);
        reset_n <= 1'b1;
        for (int i = 0; i < 10; i++) begin
            rd(8'(4 * i));
            chk(rd_v, 32'h0);
        end
        rd(8'h40);
        chk({30'h0, resp_q}, {30'h0, CDPX_RESP_SLVERR});
        chk(rd_v, 32'h0);
        wr(8'h44, 32'h1);
        chk({30'h0, resp_q}, {30'h0, CDPX_RESP_SLVERR});
        wr(`CDPX_OFF_OVR, 32'hff);
        chk({30'h0, resp_q}, {30'h0, CDPX_RESP_OKAY});
        wr(`CDPX_OFF_DT_LS_BUF, 32'h03);
        wr(`CDPX_OFF_DT_HS_BUF, 32'h05);
        rd(`CDPX_OFF_DT_HS_BUF);
        chk(rd_v, 32'h05);
        rd(`CDPX_OFF_DT_ACT);
        chk(rd_v, 32'h0);
        pulse(1'b1, 8'h00);
        rd(`CDPX_OFF_DT_ACT);
        chk(rd_v, 32'h0503);
        rd(`CDPX_OFF_STATUS);
        chk(rd_v & 32'h2, 32'h2);
        wr(`CDPX_OFF_STATUS, 32'h7);
        @(posedge mclk);
        wg_mode <= 1'b0;
        wr(`CDPX_OFF_CTRL, 32'h1);
        drive_wave(4'h0, 10);
        chk({24'h0, port_q.pin_ovr}, 32'h0);
        @(posedge mclk);
        wg_mode <= 1'b1;
        drive_wave(4'b0101, 20);
        chk({24'h0, port_q.pin_val}, 32'h99);
        chk({24'h0, port_q.pin_ovr}, 32'hff);
        drive_wave(4'b0000, 20);
        chk({24'h0, port_q.pin_val}, 32'haa);
        step_gap(4'b0001, 0);
        chk(32'(n_gap >= 3 && n_gap <= 4), 32'h1);
        chk({31'h0, halt_seen}, 32'h0);
        step_gap(4'b0000, 1);
        chk(32'(n_gap >= 5 && n_gap <= 6), 32'h1);
        wr(`CDPX_OFF_CTRL, 32'h9);
        step_gap(4'b0001, 0);
        chk({31'h0, halt_seen}, 32'h1);
        rd(`CDPX_OFF_STATUS);
        chk(rd_v & 32'h4, 32'h4);
        step_gap(4'b0000, 1);
        chk({31'h0, shoot}, 32'h0);
        wr(`CDPX_OFF_OVR, 32'h0f);
        drive_wave(4'b0000, 5);
        chk({24'h0, port_q.pin_ovr}, 32'h0f);
        wr(`CDPX_OFF_PAT_BUF, 32'ha5);
        wr(`CDPX_OFF_CTRL, 32'h2);
        drive_wave(4'b0000, 5);
        chk({24'h0, port_q.pin_val}, 32'h00);
        pulse(1'b1, 8'h00);
        drive_wave(4'hf, 20);
        chk({24'h0, port_q.pin_val}, 32'ha5);
        chk({24'h0, port_q.pin_ovr}, 32'h0f);
        wr(`CDPX_OFF_CTRL, 32'h4);
        drive_wave(4'b0001, 20);
        chk({16'h0, port_q}, 32'hffff);
        drive_wave(4'b1110, 20);
        chk({24'h0, port_q.pin_val}, 32'h00);
        wr(`CDPX_OFF_CTRL, 32'h1);
        wr(`CDPX_OFF_OVR, 32'hff);
        wr(`CDPX_OFF_FLT_SEL, 32'h04);
        wr(`CDPX_OFF_MASK, 32'h1);
        wr(`CDPX_OFF_STATUS, 32'h7);
        drive_wave(4'b0101, 20);
        pulse(1'b0, 8'h20);
        drive_wave(4'b0101, 3);
        chk({23'h0, irq, port_q.pin_val}, 32'h99);
        pulse(1'b0, 8'h04);
        @(negedge mclk);
        chk({24'h0, port_q.pin_val}, 32'h00);
        drive_wave(4'b0101, 10);
        chk({23'h0, irq, port_q.pin_val}, 32'h100);
        wr(`CDPX_OFF_MASK, 32'h0);
        drive_wave(4'b0101, 2);
        chk({31'h0, irq}, 32'h0);
        wr(`CDPX_OFF_MASK, 32'h1);
        rd(`CDPX_OFF_FAULT);
        chk(rd_v & 32'h1, 32'h1);
        wr(`CDPX_OFF_FAULT, 32'h1);
        wr(`CDPX_OFF_STATUS, 32'h7);
        drive_wave(4'b0101, 20);
        rd(`CDPX_OFF_FAULT);
        chk(rd_v & 32'h1, 32'h0);
        chk({23'h0, irq, port_q.pin_val}, 32'h99);
        finish_test();
    end
    // Cuts a hang short well beyond the few hundred cycles the sequence needs.
    initial begin
        #300000;
        failures++;
        finish_test();
    end
endmodule
